// File: src/mas_sequencer.sv
// Control word address sequencer with its core store and working registers.
// Assumes a 200 MHz clock, synchronous active-high reset, and command logic
// outside that drives the transfer selects from the decoded fields.
//
// Functional notes
// - steps at 333 kc, two steps per access
// - core store of 8192 fifteen-bit words
// - word splits into option, primary, secondary fields
// - clocks 1-2 read, rewrite, load control word
// - option sets length, address source, increments
// - direct control word: low-64 operand, address+1
// - direct memory address: operand Y+1, next Y+2
// - direct auxiliary: operand Q, auxiliary Q+1
// - direct accumulator: same, using accumulator
// - indirect options: six clocks, one extra access
// - indirect control word: pointer via secondary field
// - indirect memory address: pointer at Y+1
// - indirect auxiliary: pointer at Q, three updates
// - indirect accumulator: pointer address from accumulator
// - primary selects command; secondary address or command
// - secondary accumulator load beats automatic transfer
// - exchange register sources: core and five registers
// - address register loads, source of counting
// - auxiliary loads, holds, shifts both ways
// - accumulator loads, adds, clears, shifts, complements
// - I/O buffer loads while sequencing continues
`timescale 1ns/10ps
`default_nettype none

module mas_sequencer
   import mas_pkg::*;
#(
   parameter int unsigned STEP_DIV = STEP_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic [2:0]        xfer_e_sel,
   input  wire logic [1:0]        xfer_m_sel,
   input  wire logic [2:0]        xfer_p_op,
   input  wire logic [3:0]        xfer_a_op,
   input  wire logic [1:0]        xfer_t_sel,
   input  wire logic              io_strobe,
   input  wire logic [14:0]       io_data_in,
   output logic [2:0]             address_option_field,
   output logic [5:0]             primary_command_field,
   output logic [5:0]             secondary_field,
   output logic                   secondary_is_address,
   output logic [2:0]             clock_slot,
   output logic                   step_pulse,
   output logic                   cycle_done,
   output logic                   io_taken,
   output logic [14:0]            mar_out,
   output logic [14:0]            cwr_out,
   output logic [14:0]            mxr_out,
   output logic [14:0]            aux_out,
   output logic [14:0]            acc_out,
   output logic [14:0]            iob_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check
   generate
      if (STEP_DIV < 2 || STEP_DIV > 4095) begin : g_bad_div
         $error("mas_sequencer: STEP_DIV must lie in 2..4095");
      end
   endgenerate

   localparam logic [11:0] DIV_LAST = 12'(STEP_DIV - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [14:0] core_mem [0:MEM_WORDS-1];

   logic [11:0] div_ff;
   mas_slot_e   slot_ff;
   mas_slot_e   nxt_slot;
   logic [14:0] mar_ff;
   logic [14:0] cwr_ff;
   logic [14:0] mxr_ff;
   logic [14:0] aux_ff;
   logic [14:0] acc_ff;
   logic [14:0] iob_ff;
   logic [14:0] ptr_ff;
   logic [12:0] opaddr_ff;
   logic        done_ff;
   logic        taken_ff;
   logic        io_s1_ff;
   logic        io_s2_ff;
   logic        io_s3_ff;
   logic        io_lvl_ff;

   logic [14:0] nxt_mar;
   logic [14:0] nxt_mxr;
   logic [14:0] nxt_aux;
   logic [14:0] nxt_acc;
   logic [14:0] nxt_iob;
   logic [12:0] nxt_opaddr;

   ////////////////////////////////////////////////////////////////////////////
   // Step timing and field decode
   wire       tick      = (div_ff == DIV_LAST);
   mas_opt_e  opt;
   mas_opt_e  new_opt;
   assign opt     = mas_opt_e'(cwr_ff[OPT_LSB +: OPT_W]);
   assign new_opt = mas_opt_e'(mxr_ff[OPT_LSB +: OPT_W]);
   wire [5:0] sec_fld   = cwr_ff[SEC_LSB +: SEC_W];
   wire [5:0] new_sec   = mxr_ff[SEC_LSB +: SEC_W];
   wire       indirect  = opt[2];

   wire in_t1   = (slot_ff == SLOT_T1);
   wire in_t2   = (slot_ff == SLOT_T2);
   wire in_t4   = (slot_ff == SLOT_T4);
   wire in_t6   = (slot_ff == SLOT_T6);
   wire read_ck = (slot_ff == SLOT_T1) || (slot_ff == SLOT_T3) || (slot_ff == SLOT_T5);
   wire last_ck = indirect ? in_t6 : in_t4;
   wire t2_tick = tick && in_t2;
   wire t4_tick = tick && in_t4 && indirect;
   wire end_tk  = tick && last_ck;

   // Fetch is addressed by the address register, later accesses elsewhere
   wire [12:0] mem_addr = (in_t1 || in_t2) ? mar_ff[12:0] : opaddr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Slot sequencing
   always_comb begin
      case (slot_ff)
         SLOT_T1: nxt_slot = SLOT_T2;
         SLOT_T2: nxt_slot = SLOT_T3;
         SLOT_T3: nxt_slot = SLOT_T4;
         SLOT_T4: nxt_slot = indirect ? SLOT_T5 : SLOT_T1;
         SLOT_T5: nxt_slot = SLOT_T6;
         SLOT_T6: nxt_slot = SLOT_T1;
         default: nxt_slot = SLOT_T1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand access address, chosen as the new control word lands
   wire [14:0] mar_p1 = mar_ff + WORD_ONE;
   wire [14:0] mar_p2 = mar_ff + WORD_TWO;
   wire [14:0] aux_p1 = aux_ff + WORD_ONE;
   wire [14:0] acc_p1 = acc_ff + WORD_ONE;
   wire [14:0] ptr_p1 = ptr_ff + WORD_ONE;
   logic [12:0] first_addr;

   always_comb begin
      case (new_opt)
         direct_from_control_word,
         indirect_from_control_word:   first_addr = {7'h00, new_sec};
         direct_from_memory_address,
         indirect_from_memory_address: first_addr = mar_p1[12:0];
         direct_from_auxiliary,
         indirect_from_auxiliary:      first_addr = aux_ff[12:0];
         direct_from_accumulator,
         indirect_from_accumulator:    first_addr = acc_ff[12:0];
         default:                      first_addr = mar_ff[12:0];
      endcase
   end

   // Indirect: the word from the second access addresses the operand
   assign nxt_opaddr = t2_tick ? first_addr :
                       t4_tick ? mxr_ff[12:0] : opaddr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Address register: external load overrides the automatic advance
   wire two_step = (opt == direct_from_memory_address) ||
                   (opt == indirect_from_memory_address);
   wire [14:0] mar_auto = two_step ? mar_p2 : mar_p1;
   wire [14:0] mar_ext  = (xfer_m_sel == XM_MXR) ? mxr_ff :
                          (xfer_m_sel == XM_ACC) ? acc_ff : aux_ff;
   assign nxt_mar = !end_tk                ? mar_ff  :
                    (xfer_m_sel != XM_HOLD) ? mar_ext : mar_auto;

   ////////////////////////////////////////////////////////////////////////////
   // Exchange register: core read on read clocks, transfers at cycle end
   wire [14:0] mxr_ext = (xfer_e_sel == XE_ACC) ? acc_ff :
                         (xfer_e_sel == XE_AUX) ? aux_ff :
                         (xfer_e_sel == XE_MAR) ? mar_ff :
                         (xfer_e_sel == XE_CWR) ? cwr_ff :
                         (xfer_e_sel == XE_IOB) ? iob_ff : mxr_ff;
   assign nxt_mxr = (tick && read_ck) ? core_mem[mem_addr] :
                    end_tk ? mxr_ext : mxr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Auxiliary register: automatic string advance wins over its own ops
   logic        aux_auto_en;
   logic [14:0] aux_auto;

   always_comb begin
      case (opt)
         direct_from_auxiliary,
         indirect_from_auxiliary: begin
            aux_auto_en = 1'b1;
            aux_auto    = aux_p1;
         end
         indirect_from_control_word,
         indirect_from_memory_address,
         indirect_from_accumulator: begin
            aux_auto_en = 1'b1;
            aux_auto    = ptr_p1;
         end
         default: begin
            aux_auto_en = 1'b0;
            aux_auto    = aux_ff;
         end
      endcase
   end

   wire [14:0] aux_ext = (xfer_p_op == XP_MAR) ? mar_ff :
                         (xfer_p_op == XP_MXR) ? mxr_ff :
                         (xfer_p_op == XP_ACC) ? acc_ff :
                         (xfer_p_op == XP_SHL) ? {aux_ff[13:0], 1'b0} :
                         (xfer_p_op == XP_SHR) ? {1'b0, aux_ff[14:1]} :
                         aux_ff;
   assign nxt_aux = !end_tk ? aux_ff : (aux_auto_en ? aux_auto : aux_ext);

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator: a commanded load takes precedence over the option's
   logic        acc_auto_en;
   logic [14:0] acc_auto;

   always_comb begin
      case (opt)
         direct_from_accumulator,
         indirect_from_accumulator: begin
            acc_auto_en = 1'b1;
            acc_auto    = acc_p1;
         end
         indirect_from_auxiliary: begin
            acc_auto_en = 1'b1;
            acc_auto    = ptr_p1;
         end
         default: begin
            acc_auto_en = 1'b0;
            acc_auto    = acc_ff;
         end
      endcase
   end

   logic [14:0] acc_ext;

   always_comb begin
      case (xfer_a_op)
         XA_CLR:  acc_ext = WORD_RST;
         XA_SHL:  acc_ext = {acc_ff[13:0], 1'b0};
         XA_SHR:  acc_ext = {1'b0, acc_ff[14:1]};
         XA_CPL:  acc_ext = ~acc_ff;
         XA_MAR:  acc_ext = mar_ff;
         XA_AUX:  acc_ext = aux_ff;
         XA_MXR:  acc_ext = mxr_ff;
         XA_ADD:  acc_ext = acc_ff + mxr_ff;
         default: acc_ext = acc_ff;
      endcase
   end

   wire acc_cmd = (xfer_a_op != XA_HOLD);
   assign nxt_acc = !end_tk ? acc_ff :
                    acc_cmd ? acc_ext : acc_auto;

   ////////////////////////////////////////////////////////////////////////////
   // I/O buffer: external strobe served in any slot, beside the sequence
   wire io_rise = io_s2_ff && io_s3_ff && !io_lvl_ff;
   assign nxt_iob = io_rise ? io_data_in :
                    (end_tk && xfer_t_sel == XT_ACC) ? acc_ff :
                    (end_tk && xfer_t_sel == XT_MXR) ? mxr_ff : iob_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Core store: every read is followed by a rewrite of the exchange word
   // Plain always so the store can still be preloaded hierarchically
   always @(posedge clock) begin
      if (tick && !read_ck) begin
         core_mem[mem_addr] <= mxr_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   always_ff @(posedge clock) begin
      if (srst) begin
         div_ff  <= 12'h000;
         slot_ff <= SLOT_T1;
         done_ff <= 1'b0;
      end else begin
         div_ff  <= tick ? 12'h000 : div_ff + 12'h001;
         slot_ff <= tick ? nxt_slot : slot_ff;
         done_ff <= end_tk;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cwr_ff    <= WORD_RST;
         ptr_ff    <= WORD_RST;
         opaddr_ff <= 13'h0000;
      end else begin
         cwr_ff    <= t2_tick ? mxr_ff : cwr_ff;
         ptr_ff    <= t4_tick ? mxr_ff : ptr_ff;
         opaddr_ff <= nxt_opaddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Working registers
   always_ff @(posedge clock) begin
      if (srst) begin
         mar_ff <= WORD_RST;
         mxr_ff <= WORD_RST;
         aux_ff <= WORD_RST;
         acc_ff <= WORD_RST;
         iob_ff <= WORD_RST;
      end else begin
         mar_ff <= nxt_mar;
         mxr_ff <= nxt_mxr;
         aux_ff <= nxt_aux;
         acc_ff <= nxt_acc;
         iob_ff <= nxt_iob;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobe synchroniser and acceptance
   always_ff @(posedge clock) begin
      if (srst) begin
         io_s1_ff  <= 1'b0;
         io_s2_ff  <= 1'b0;
         io_s3_ff  <= 1'b0;
         io_lvl_ff <= 1'b0;
         taken_ff  <= 1'b0;
      end else begin
         io_s1_ff  <= io_strobe;
         io_s2_ff  <= io_s1_ff;
         io_s3_ff  <= io_s2_ff;
         io_lvl_ff <= (io_s2_ff == io_s3_ff) ? io_s3_ff : io_lvl_ff;
         taken_ff  <= io_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign address_option_field  = cwr_ff[OPT_LSB +: OPT_W];
   assign primary_command_field = cwr_ff[PRI_LSB +: PRI_W];
   assign secondary_field       = sec_fld;
   assign secondary_is_address  = (opt == direct_from_control_word) ||
                                  (opt == indirect_from_control_word);
   assign clock_slot            = slot_ff;
   assign step_pulse            = tick;
   assign cycle_done            = done_ff;
   assign io_taken              = taken_ff;
   assign mar_out               = mar_ff;
   assign cwr_out               = cwr_ff;
   assign mxr_out               = mxr_ff;
   assign aux_out               = aux_ff;
   assign acc_out               = acc_ff;
   assign iob_out               = iob_ff;

endmodule // mas_sequencer

`default_nettype wire

// File: include/mas_pkg.sv
// Shared constants for the control word address sequencer.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
package mas_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clocking
   localparam int unsigned CLK_HZ      = 200_000_000;
   localparam int unsigned STEP_HZ     = 333_000;
   // Longest step period that still meets the step rate, so round down
   localparam int unsigned STEP_CYCLES = CLK_HZ / STEP_HZ;

   ////////////////////////////////////////////////////////////////////////////
   // Word, store and field layout
   localparam int unsigned WORD_W    = 15;
   localparam int unsigned ADDR_W    = 13;
   localparam int unsigned MEM_WORDS = 8192;
   localparam int unsigned OPT_LSB   = 12;
   localparam int unsigned OPT_W     = 3;
   localparam int unsigned PRI_LSB   = 6;
   localparam int unsigned PRI_W     = 6;
   localparam int unsigned SEC_LSB   = 0;
   localparam int unsigned SEC_W     = 6;

   localparam logic [14:0] WORD_RST  = 15'h0000;
   localparam logic [14:0] WORD_ONE  = 15'h0001;
   localparam logic [14:0] WORD_TWO  = 15'h0002;

   ////////////////////////////////////////////////////////////////////////////
   // Address options
   typedef enum logic [2:0] {
      direct_from_control_word     = 3'h0,
      direct_from_memory_address   = 3'h1,
      direct_from_auxiliary        = 3'h2,
      direct_from_accumulator      = 3'h3,
      indirect_from_control_word   = 3'h4,
      indirect_from_memory_address = 3'h5,
      indirect_from_auxiliary      = 3'h6,
      indirect_from_accumulator    = 3'h7
   } mas_opt_e;

   ////////////////////////////////////////////////////////////////////////////
   // Clock slots within one control word cycle, Gray coded except the T6 to T1 return
   typedef enum logic [2:0] {
      SLOT_T1 = 3'h0,
      SLOT_T2 = 3'h1,
      SLOT_T3 = 3'h3,
      SLOT_T4 = 3'h2,
      SLOT_T5 = 3'h6,
      SLOT_T6 = 3'h7
   } mas_slot_e;

   ////////////////////////////////////////////////////////////////////////////
   // Register transfer selects
   localparam logic [2:0] XE_HOLD = 3'h0;
   localparam logic [2:0] XE_ACC  = 3'h1;
   localparam logic [2:0] XE_AUX  = 3'h2;
   localparam logic [2:0] XE_MAR  = 3'h3;
   localparam logic [2:0] XE_CWR  = 3'h4;
   localparam logic [2:0] XE_IOB  = 3'h5;

   localparam logic [1:0] XM_HOLD = 2'h0;
   localparam logic [1:0] XM_MXR  = 2'h1;
   localparam logic [1:0] XM_ACC  = 2'h2;
   localparam logic [1:0] XM_AUX  = 2'h3;

   localparam logic [2:0] XP_HOLD = 3'h0;
   localparam logic [2:0] XP_MAR  = 3'h1;
   localparam logic [2:0] XP_MXR  = 3'h2;
   localparam logic [2:0] XP_ACC  = 3'h3;
   localparam logic [2:0] XP_SHL  = 3'h4;
   localparam logic [2:0] XP_SHR  = 3'h5;

   localparam logic [3:0] XA_HOLD = 4'h0;
   localparam logic [3:0] XA_CLR  = 4'h1;
   localparam logic [3:0] XA_SHL  = 4'h2;
   localparam logic [3:0] XA_SHR  = 4'h3;
   localparam logic [3:0] XA_CPL  = 4'h4;
   localparam logic [3:0] XA_MAR  = 4'h5;
   localparam logic [3:0] XA_AUX  = 4'h6;
   localparam logic [3:0] XA_MXR  = 4'h7;
   localparam logic [3:0] XA_ADD  = 4'h8;

   localparam logic [1:0] XT_HOLD = 2'h0;
   localparam logic [1:0] XT_ACC  = 2'h1;
   localparam logic [1:0] XT_MXR  = 2'h2;

endpackage

// File: verification/mas_seq_checker.sv
// Checker for step timing, field decode, cycle length and I/O capture.
// Assumes it is bound into mas_sequencer and shares its STEP_DIV.
`timescale 1ns/10ps
`default_nettype none

module mas_seq_checker
   import mas_pkg::*;
#(
   parameter int unsigned STEP_DIV = STEP_CYCLES
) (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic [1:0]  xfer_m_sel,
   input wire logic        io_strobe,
   input wire logic [14:0] io_data_in,
   input wire logic [2:0]  address_option_field,
   input wire logic [5:0]  primary_command_field,
   input wire logic [5:0]  secondary_field,
   input wire logic        secondary_is_address,
   input wire logic [2:0]  clock_slot,
   input wire logic        step_pulse,
   input wire logic        cycle_done,
   input wire logic        io_taken,
   input wire logic [14:0] mar_out,
   input wire logic [14:0] cwr_out,
   input wire logic [14:0] mxr_out,
   input wire logic [14:0] iob_out
);
   logic [11:0] div_ff;
   logic [11:0] nxt_div;
   logic        end_tick;
   logic [14:0] mar_next;

   ////////////////////////////////////////////////////////////////////////////
   // Reference step divider and end-of-cycle decode
   assign nxt_div  = (div_ff == 12'(STEP_DIV - 1)) ? 12'h000 : div_ff + 12'h001;
   assign end_tick = step_pulse && (address_option_field[2] ? clock_slot == SLOT_T6
                                                            : clock_slot == SLOT_T4);
   assign mar_next = mar_out + ((address_option_field[1:0] == 2'b01) ? WORD_TWO : WORD_ONE);

   always_ff @(posedge clock) begin
      if (srst) begin
         div_ff <= 12'h000;
      end else begin
         div_ff <= nxt_div;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   a_step_period: assert property (step_pulse == (div_ff == 12'(STEP_DIV - 1)))
      else $error("step pulse off its period");
   a_slot_still: assert property (!step_pulse |=> $stable(clock_slot))
      else $error("slot moved without a step");
   a_cwr_fetch: assert property (step_pulse && clock_slot == SLOT_T2 |=> cwr_out == $past(mxr_out))
      else $error("control word not loaded from exchange");
   a_field_split: assert property ({address_option_field, primary_command_field, secondary_field} == cwr_out)
      else $error("field split wrong");
   a_sec_address: assert property (secondary_is_address == (address_option_field[1:0] == 2'b00))
      else $error("secondary address flag wrong");
   a_short_cycle: assert property (step_pulse && clock_slot == SLOT_T4 && !address_option_field[2]
      |=> cycle_done && clock_slot == SLOT_T1) else $error("direct cycle not four steps");
   a_long_cycle: assert property (step_pulse && clock_slot == SLOT_T4 && address_option_field[2]
      |=> !cycle_done && clock_slot == SLOT_T5) else $error("indirect cycle ended early");
   a_done_cause: assert property (cycle_done |-> $past(end_tick))
      else $error("cycle done without end step");
   a_mar_advance: assert property (end_tick && xfer_m_sel == XM_HOLD |=> mar_out == $past(mar_next))
      else $error("address register advance wrong");
   a_io_capture: assert property (io_taken |-> iob_out == io_data_in)
      else $error("buffer does not hold strobed data");
   a_io_latency: assert property ($rose(io_strobe) |-> ##[2:8] io_taken)
      else $error("strobe not taken in time");
endmodule // mas_seq_checker

`default_nettype wire

// File: verification/mas_io_peripheral.sv
// Slow peripheral on the external data lines of the I/O buffer.
// Assumes the bench calls send and waits for it to return.
`timescale 1ns/10ps
`default_nettype none

module mas_io_peripheral (
   input  wire logic        clock,
   input  wire logic        io_taken,
   output logic             io_strobe,
   output logic [14:0]      io_data_in
);
   initial begin
      io_strobe  = 1'b0;
      io_data_in = 15'h0000;
   end

   // Hold data until taken or 20 clocks pass, then scramble the released lines
   task automatic send(input logic [14:0] data, output bit ok);
      ok = 1'b0;
      @(posedge clock);
      io_strobe  <= 1'b1;
      io_data_in <= data;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge clock);
         ok = (io_taken === 1'b1);
      end
      io_strobe  <= 1'b0;
      io_data_in <= ~data;
   endtask
endmodule // mas_io_peripheral

`default_nettype wire

// File: verification/mas_sequencer_bench.sv
// Bench: runs one control word of every option, then I/O during a cycle.
// Assumes the core store is visible as mas_sequencer_i.core_mem.
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
   end \
end

module mas_sequencer_bench
   import mas_pkg::*;
;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic [2:0]  xfer_e_sel = XE_HOLD;
   logic [1:0]  xfer_m_sel = XM_HOLD;
   logic [2:0]  xfer_p_op = XP_HOLD;
   logic [3:0]  xfer_a_op = XA_HOLD;
   logic [1:0]  xfer_t_sel = XT_HOLD;
   logic        io_strobe, io_taken, secondary_is_address, step_pulse, cycle_done;
   logic [14:0] io_data_in, mar_out, cwr_out, mxr_out, aux_out, acc_out, iob_out;
   logic [2:0]  address_option_field, clock_slot;
   logic [5:0]  primary_command_field, secondary_field;
   int          n_errors = 0;
   int          total_checks = 0;

   always #2.5 clock = ~clock;

   mas_sequencer #(.STEP_DIV(4)) mas_sequencer_i (
      .clock(clock), .srst(srst), .xfer_e_sel(xfer_e_sel), .xfer_m_sel(xfer_m_sel),
      .xfer_p_op(xfer_p_op), .xfer_a_op(xfer_a_op), .xfer_t_sel(xfer_t_sel),
      .io_strobe(io_strobe), .io_data_in(io_data_in),
      .address_option_field(address_option_field),
      .primary_command_field(primary_command_field), .secondary_field(secondary_field),
      .secondary_is_address(secondary_is_address), .clock_slot(clock_slot),
      .step_pulse(step_pulse), .cycle_done(cycle_done), .io_taken(io_taken),
      .mar_out(mar_out), .cwr_out(cwr_out), .mxr_out(mxr_out), .aux_out(aux_out),
      .acc_out(acc_out), .iob_out(iob_out));

   mas_io_peripheral mas_io_peripheral_i (
      .clock(clock), .io_taken(io_taken), .io_strobe(io_strobe), .io_data_in(io_data_in));

   function automatic logic [14:0] cw(input logic [2:0] o, input logic [5:0] p, s);
      return {o, p, s};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic load_program;
      logic [14:0] prog [12] = '{cw(3'h0, 6'h05, 6'h20), cw(3'h1, 6'h03, 6'h00), 15'h0abc,
         cw(3'h2, 6'h00, 6'h00), cw(3'h3, 6'h00, 6'h00), cw(3'h3, 6'h00, 6'h07),
         cw(3'h4, 6'h00, 6'h21), cw(3'h5, 6'h00, 6'h00), 15'h0200,
         cw(3'h6, 6'h00, 6'h00), cw(3'h7, 6'h00, 6'h00), cw(3'h0, 6'h00, 6'h22)};
      logic [29:0] dat [12] = '{{15'h0020, 15'h1234}, {15'h0021, 15'h0100},
         {15'h0022, 15'h0011}, {15'h0100, 15'h4444}, {15'h0200, 15'h0777},
         {15'h0201, 15'h0300}, {15'h0300, 15'h0888}, {15'h0301, 15'h0400},
         {15'h0400, 15'h0999}, {15'h0abc, 15'h0555}, {15'h1234, 15'h2222},
         {15'h1235, 15'h3333}};
      for (int i = 0; i < 8192; i++) begin
         mas_sequencer_i.core_mem[i] = 15'h0000;
      end
      for (int i = 0; i < 12; i++) begin
         mas_sequencer_i.core_mem[i] = prog[i];
         mas_sequencer_i.core_mem[dat[i][27:15]] = dat[i][14:0];
      end
   endtask

   task automatic run_cycle(input logic [2:0] e, input logic [1:0] m, input logic [2:0] p,
                            input logic [3:0] a, input logic [1:0] t);
      int n;
      @(posedge clock);
      xfer_e_sel <= e;
      xfer_m_sel <= m;
      xfer_p_op  <= p;
      xfer_a_op  <= a;
      xfer_t_sel <= t;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (cycle_done === 1'b1) break;
      end
      `CHK(n < 40, 1'b1)
      xfer_e_sel <= XE_HOLD;
      xfer_m_sel <= XM_HOLD;
      xfer_p_op  <= XP_HOLD;
      xfer_a_op  <= XA_HOLD;
      xfer_t_sel <= XT_HOLD;
   endtask

   task automatic expect4(input logic [14:0] m, x, p, a);
      `CHK(mar_out, m)
      `CHK(mxr_out, x)
      `CHK(aux_out, p)
      `CHK(acc_out, a)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios, one control word each, in program order
   task automatic chk_direct_cw;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_MXR, XT_HOLD);
      expect4(15'h0001, 15'h1234, 15'h0000, 15'h1234);
      `CHK(cwr_out, cw(3'h0, 6'h05, 6'h20))
      `CHK(secondary_is_address, 1'b1)
   endtask

   task automatic chk_direct_mem;
      run_cycle(XE_HOLD, XM_HOLD, XP_MXR, XA_HOLD, XT_HOLD);
      expect4(15'h0003, 15'h0abc, 15'h0abc, 15'h1234);
      `CHK(address_option_field, direct_from_memory_address)
      `CHK(primary_command_field, 6'h03)
   endtask

   task automatic chk_direct_aux;
      run_cycle(XE_HOLD, XM_HOLD, XP_SHL, XA_HOLD, XT_HOLD);
      expect4(15'h0004, 15'h0555, 15'h0abd, 15'h1234);
   endtask

   task automatic chk_direct_acc;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_HOLD, XT_HOLD);
      expect4(15'h0005, 15'h2222, 15'h0abd, 15'h1235);
   endtask

   task automatic chk_acc_priority;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_CLR, XT_HOLD);
      expect4(15'h0006, 15'h3333, 15'h0abd, 15'h0000);
      `CHK(secondary_is_address, 1'b0)
   endtask

   task automatic chk_ind_cw;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_HOLD, XT_HOLD);
      expect4(15'h0007, 15'h4444, 15'h0101, 15'h0000);
   endtask

   task automatic chk_ind_mem;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_HOLD, XT_HOLD);
      expect4(15'h0009, 15'h0777, 15'h0201, 15'h0000);
   endtask

   task automatic chk_ind_aux;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_HOLD, XT_HOLD);
      expect4(15'h000a, 15'h0888, 15'h0202, 15'h0301);
   endtask

   task automatic chk_ind_acc;
      run_cycle(XE_HOLD, XM_HOLD, XP_HOLD, XA_HOLD, XT_HOLD);
      expect4(15'h000b, 15'h0999, 15'h0401, 15'h0302);
   endtask

   task automatic chk_transfers;
      run_cycle(XE_AUX, XM_ACC, XP_HOLD, XA_HOLD, XT_ACC);
      expect4(15'h0302, 15'h0401, 15'h0401, 15'h0302);
      `CHK(iob_out, 15'h0302)
   endtask

   task automatic chk_io_overlap;
      bit ok;
      fork
         mas_io_peripheral_i.send(15'h2a5a, ok);
         run_cycle(XE_MAR, XM_HOLD, XP_SHR, XA_ADD, XT_HOLD);
      join
      `CHK(ok, 1'b1)
      `CHK(iob_out, 15'h2a5a)
      `CHK(mar_out, 15'h0303)
      expect4(15'h0303, 15'h0302, 15'h0200, 15'h0462);
   endtask

   task automatic chk_more_xfers;
      run_cycle(XE_IOB, XM_AUX, XP_ACC, XA_CPL, XT_MXR);
      expect4(15'h0200, 15'h2a5a, 15'h0462, 15'h7b9d);
      `CHK(iob_out, 15'h0160)
   endtask

   task automatic print_verdict;
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      load_program();
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      chk_direct_cw();
      chk_direct_mem();
      chk_direct_aux();
      chk_direct_acc();
      chk_acc_priority();
      chk_ind_cw();
      chk_ind_mem();
      chk_ind_aux();
      chk_ind_acc();
      chk_transfers();
      chk_io_overlap();
      chk_more_xfers();
      print_verdict();
   end

   initial begin
      repeat (3000) @(posedge clock);
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule // mas_sequencer_bench

bind mas_sequencer mas_seq_checker #(.STEP_DIV(STEP_DIV)) mas_seq_checker_i (
   .clock(clock), .srst(srst), .xfer_m_sel(xfer_m_sel), .io_strobe(io_strobe),
   .io_data_in(io_data_in), .address_option_field(address_option_field),
   .primary_command_field(primary_command_field), .secondary_field(secondary_field),
   .secondary_is_address(secondary_is_address), .clock_slot(clock_slot),
   .step_pulse(step_pulse), .cycle_done(cycle_done), .io_taken(io_taken),
   .mar_out(mar_out), .cwr_out(cwr_out), .mxr_out(mxr_out), .iob_out(iob_out));

`default_nettype wire
